// >>> hdl/tsi_switch_map.svh
// Constants for the time slot interchange switch: field positions, counts, reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TSI_SWITCH_MAP_SVH
`define TSI_SWITCH_MAP_SVH
`define TSI_STREAMS          4
`define TSI_CHANNELS         32
`define TSI_BITS             8
`define TSI_SLOTS            128
`define TSI_CLK_HZ           40000000
`define TSI_RESET_MIN_NS     100
`define TSI_ADDR_REG_SEL     5
`define TSI_CTL_SPLIT        7
`define TSI_CTL_PROC_EN      6
`define TSI_CTL_MSEL_HI      4
`define TSI_CTL_MSEL_LO      3
`define TSI_CTL_STREAM_HI    1
`define TSI_CTL_STREAM_LO    0
`define TSI_CHAN_SOURCE      2
`define TSI_CHAN_OUT_EN      0
`define TSI_MSEL_DATA        2'h0
`define TSI_MSEL_SRC         2'h2
`define TSI_MSEL_CTL         2'h3
`define TSI_CTL_RESET        8'h00
`define TSI_FIFO_DEPTH       8
`endif

// >>> hdl/tsi_switch_pkg.sv
// Types shared by the time slot interchange switch files.
// Assumes the constant header sits beside it in hdl/.
`include "tsi_switch_map.svh"
package tsi_switch_pkg;
   typedef struct packed
   {
      logic [6:0] slot;
      logic [7:0] data;
   } rx_word_t;

   typedef struct packed
   {
      logic       cs_n;
      logic       strobe;
      logic       read;
      logic [5:0] addr;
   } host_req_t;

   typedef enum logic [1:0] {HOST_IDLE, HOST_DONE} host_state_t;
endpackage : tsi_switch_pkg

// >>> hdl/tsi_switch.sv
// Time slot interchange switch: 4 x 32 channel streams, data memory, connection memory,
// host strobe port. Assumes the serial clock, frame pulse and host pins arrive asynchronously
// to clk_i (40 MHz) and are synchronised here; the board resolves three-state wires.
`include "tsi_switch_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tsi_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : tsi_fifo

////////////////////////////////////////////////////////////////////////////////
module tsi_switch (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // Serial side
   input  wire logic       serial_shift_clock_i,
   input  wire logic       frame_sync_in_n_i,
   input  wire logic [3:0] serial_in_lines_i,
   output logic [3:0]      serial_out_lines_o,
   output logic [3:0]      serial_out_lines_oe_o,
   input  wire logic       master_output_enable_i,
   // Host port
   input  wire logic       chip_select_n_i,
   input  wire logic       data_strobe_i,
   input  wire logic       read_not_write_i,
   input  wire logic [5:0] host_addr_lines_i,
   input  wire logic [7:0] host_data_lines_i,
   output logic [7:0]      host_data_lines_o,
   output logic            host_data_lines_oe_o,
   output logic            transfer_done_ack_o,
   output logic            transfer_done_ack_oe_o
);
   // Two-stage synchronisers on every asynchronous pin
   logic [1:0] clk_s;
   logic [1:0] fs_s;
   logic [1:0] men_s;
   logic [3:0] rx_s1;
   logic [3:0] rx_s2;
   logic [1:0] cs_s;
   logic [1:0] strb_s;
   logic [1:0] rw_s;
   logic [5:0] addr_s1;
   logic [5:0] addr_s2;
   logic [7:0] din_s1;
   logic [7:0] din_s2;
   logic       clk_d;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         clk_s   <= 2'h0;
         fs_s    <= 2'h3;
         men_s   <= 2'h0;
         rx_s1   <= 4'h0;
         rx_s2   <= 4'h0;
         cs_s    <= 2'h3;
         strb_s  <= 2'h0;
         rw_s    <= 2'h0;
         addr_s1 <= 6'h00;
         addr_s2 <= 6'h00;
         din_s1  <= 8'h00;
         din_s2  <= 8'h00;
         clk_d   <= 1'b0;
      end
      else
      begin
         clk_s   <= {clk_s[0], serial_shift_clock_i};
         fs_s    <= {fs_s[0], frame_sync_in_n_i};
         men_s   <= {men_s[0], master_output_enable_i};
         rx_s1   <= serial_in_lines_i;
         rx_s2   <= rx_s1;
         cs_s    <= {cs_s[0], chip_select_n_i};
         strb_s  <= {strb_s[0], data_strobe_i};
         rw_s    <= {rw_s[0], read_not_write_i};
         addr_s1 <= host_addr_lines_i;
         addr_s2 <= addr_s1;
         din_s1  <= host_data_lines_i;
         din_s2  <= din_s1;
         clk_d   <= clk_s[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit timing: two serial clocks per bit, frame pulse low across a falling edge
   logic       clk_fall;
   logic       clk_rise;
   logic       half;
   logic [2:0] bit_cnt;
   logic [4:0] chan_cnt;
   logic [7:0] shift_in [`TSI_STREAMS];
   logic       frame_seen;

   assign clk_fall = clk_d && !clk_s[1];
   assign clk_rise = !clk_d && clk_s[1];

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         half       <= 1'b0;
         bit_cnt    <= 3'h0;
         chan_cnt   <= 5'h00;
         frame_seen <= 1'b0;
      end
      else if (clk_fall)
      begin
         if (!fs_s[1])
         begin
            // Frame start: channel 0, bit 0 begins at this edge
            half       <= 1'b0;
            bit_cnt    <= 3'h0;
            chan_cnt   <= 5'h00;
            frame_seen <= 1'b1;
         end
         else
         begin
            half <= !half;
            if (half)
            begin
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'(`TSI_BITS - 1))
                  chan_cnt <= chan_cnt + 5'h01;
            end
         end
      end
   end

   // Input sampled three quarters into the bit on the rising edge of the second serial clock
   logic sample_en;
   logic last_bit;
   assign sample_en = clk_rise && half && frame_seen;
   assign last_bit  = (bit_cnt == 3'(`TSI_BITS - 1));

   genvar gs;
   generate
      for (gs = 0; gs < `TSI_STREAMS; gs++)
      begin : g_rx
         always_ff @(posedge clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
               shift_in[gs] <= 8'h00;
            else if (sample_en)
               shift_in[gs] <= {shift_in[gs][6:0], rx_s2[gs]};
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Received bytes queue through the FIFO into data memory, one per clk cycle
   tsi_switch_pkg::rx_word_t fifo_in;
   tsi_switch_pkg::rx_word_t fifo_out;
   logic                     fifo_in_valid;
   logic                     fifo_in_ready;
   logic                     fifo_out_valid;
   logic [1:0]               store_idx;
   logic                     store_busy;
   logic [7:0]               capture [`TSI_STREAMS];
   logic [4:0]               cap_chan;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         store_busy <= 1'b0;
         store_idx  <= 2'h0;
         cap_chan   <= 5'h00;
         for (int i = 0; i < `TSI_STREAMS; i++)
            capture[i] <= 8'h00;
      end
      else if (sample_en && last_bit)
      begin
         store_busy <= 1'b1;
         store_idx  <= 2'h0;
         cap_chan   <= chan_cnt;
         for (int i = 0; i < `TSI_STREAMS; i++)
            capture[i] <= {shift_in[i][6:0], rx_s2[i]};
      end
      else if (store_busy && fifo_in_ready)
      begin
         store_idx <= store_idx + 2'h1;
         if (store_idx == 2'(`TSI_STREAMS - 1))
            store_busy <= 1'b0;
      end
   end

   // A stall here only delays the bytes; over nineteen clk cycles exist per serial bit
   assign fifo_in_valid = store_busy;
   assign fifo_in.slot  = {store_idx, cap_chan};
   assign fifo_in.data  = capture[store_idx];

   tsi_fifo #(
      .WIDTH ($bits(tsi_switch_pkg::rx_word_t)),
      .DEPTH (`TSI_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fifo_in),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (1'b1),
      .out_data_o  (fifo_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Memories: 128 data bytes, 128 connection words split in two halves
   logic [7:0] data_mem [`TSI_SLOTS];
   logic [7:0] src_mem  [`TSI_SLOTS];
   logic [7:0] ctl_mem  [`TSI_SLOTS];
   logic [7:0] ctl_reg;
   logic       host_wr;
   logic [6:0] host_slot;

   assign host_slot = {ctl_reg[`TSI_CTL_STREAM_HI:`TSI_CTL_STREAM_LO], addr_s2[4:0]};

   always_ff @(posedge clk_i)
   begin
      if (fifo_out_valid)
         data_mem[fifo_out.slot] <= fifo_out.data;
      if (host_wr && addr_s2[`TSI_ADDR_REG_SEL] &&
          ctl_reg[`TSI_CTL_MSEL_HI:`TSI_CTL_MSEL_LO] == `TSI_MSEL_SRC)
         src_mem[host_slot] <= din_s2;
      if (host_wr && addr_s2[`TSI_ADDR_REG_SEL] &&
          ctl_reg[`TSI_CTL_MSEL_HI:`TSI_CTL_MSEL_LO] == `TSI_MSEL_CTL)
         ctl_mem[host_slot] <= din_s2;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output: next channel's byte fetched during the current slot, loaded at slot end
   logic [4:0] next_chan;
   logic [7:0] out_shift [`TSI_STREAMS];
   logic [3:0] out_en;
   logic       load_en;
   logic       shift_en;

   assign next_chan = chan_cnt + 5'h01;
   assign load_en   = clk_fall && half && last_bit && fs_s[1] && frame_seen;
   assign shift_en  = clk_fall && half && !last_bit && fs_s[1];

   function automatic logic [8:0] pick_byte(input logic [6:0] slot, input logic proc_en);
      logic [7:0] chan_ctl;
      chan_ctl = ctl_mem[slot];
      // Channels sourced from the processor by their own source bit still obey their enable bit; proc_en forces every enable
      if (proc_en || chan_ctl[`TSI_CHAN_SOURCE])
         pick_byte = {chan_ctl[`TSI_CHAN_OUT_EN], src_mem[slot]};
      else
         pick_byte = {chan_ctl[`TSI_CHAN_OUT_EN], data_mem[src_mem[slot][6:0]]};
      if (proc_en)
         pick_byte[8] = 1'b1;
   endfunction : pick_byte

   genvar go;
   generate
      for (go = 0; go < `TSI_STREAMS; go++)
      begin : g_tx
         logic [8:0] fetched;
         // Frame start reloads channel 0 too
         logic [4:0] fetch_chan;
         assign fetch_chan = fs_s[1] ? next_chan : 5'h00;
         // Process form so memory writes re-evaluate the fetch, not only slot changes
         always_comb fetched = pick_byte({2'(go), fetch_chan}, ctl_reg[`TSI_CTL_PROC_EN]);
         always_ff @(posedge clk_i or negedge resetn_i)
         begin
            if (!resetn_i)
            begin
               out_shift[go] <= 8'h00;
               out_en[go]    <= 1'b0;
            end
            else if (load_en || (clk_fall && !fs_s[1]))
            begin
               out_shift[go] <= fetched[7:0];
               out_en[go]    <= fetched[8];
            end
            else if (shift_en)
               out_shift[go] <= {out_shift[go][6:0], 1'b0};
         end
         assign serial_out_lines_o[go]    = out_shift[go][7];
         assign serial_out_lines_oe_o[go] = out_en[go] && men_s[1];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Host port: one access per strobe, acknowledge held until strobe or select drops
   tsi_switch_pkg::host_state_t host_state;
   logic                        access;
   logic [7:0]                  rd_data;
   logic                        rd_active;

   assign access  = !cs_s[1] && strb_s[1];
   assign host_wr = access && !rw_s[1] && host_state == tsi_switch_pkg::HOST_IDLE;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         host_state <= tsi_switch_pkg::HOST_IDLE;
         ctl_reg    <= `TSI_CTL_RESET;
         rd_data    <= 8'h00;
         rd_active  <= 1'b0;
      end
      else
      begin
         case (host_state)
            tsi_switch_pkg::HOST_IDLE:
               if (access)
               begin
                  host_state <= tsi_switch_pkg::HOST_DONE;
                  rd_active  <= rw_s[1];
                  if (!addr_s2[`TSI_ADDR_REG_SEL])
                  begin
                     rd_data <= ctl_reg;
                     if (!rw_s[1])
                        ctl_reg <= din_s2;
                  end
                  else if (ctl_reg[`TSI_CTL_SPLIT] ||
                           ctl_reg[`TSI_CTL_MSEL_HI:`TSI_CTL_MSEL_LO] == `TSI_MSEL_DATA)
                     rd_data <= data_mem[host_slot];
                  else if (ctl_reg[`TSI_CTL_MSEL_HI:`TSI_CTL_MSEL_LO] == `TSI_MSEL_SRC)
                     rd_data <= src_mem[host_slot];
                  else
                     rd_data <= ctl_mem[host_slot];
               end
            tsi_switch_pkg::HOST_DONE:
               if (!access)
               begin
                  host_state <= tsi_switch_pkg::HOST_IDLE;
                  rd_active  <= 1'b0;
               end
            default:
               host_state <= tsi_switch_pkg::HOST_IDLE;
         endcase
      end
   end

   assign host_data_lines_o      = rd_data;
   assign host_data_lines_oe_o   = rd_active && !cs_s[1];
   assign transfer_done_ack_o    = 1'b0;
   assign transfer_done_ack_oe_o = (host_state == tsi_switch_pkg::HOST_DONE);

   ////////////////////////////////////////////////////////////////////////////////
   a_master_floats: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !men_s[1] |-> serial_out_lines_oe_o == 4'h0)
      else $error("output driven with master enable low");
   a_ack_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
      host_state == tsi_switch_pkg::HOST_IDLE && access |=> transfer_done_ack_oe_o)
      else $error("no acknowledge after access");
   a_ack_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
      transfer_done_ack_oe_o && !access |=> !transfer_done_ack_oe_o)
      else $error("acknowledge not released");
   a_no_select: assert property (@(posedge clk_i) disable iff (!resetn_i)
      cs_s[1] |-> !host_data_lines_oe_o && !host_wr) else $error("port active unselected");
   a_read_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
      host_data_lines_oe_o |-> $past(rw_s[1])) else $error("data driven on write");
   a_frame_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
      clk_fall && !fs_s[1] |=> chan_cnt == 5'h00 && bit_cnt == 3'h0)
      else $error("frame did not restart counter");
   a_ctl_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
      host_state == tsi_switch_pkg::HOST_IDLE && access && !rw_s[1] &&
      !addr_s2[`TSI_ADDR_REG_SEL] |=> ctl_reg == $past(din_s2))
      else $error("control register not written");
   a_chan_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
      clk_fall && fs_s[1] && half && last_bit |=> chan_cnt == $past(chan_cnt) + 5'h01)
      else $error("channel counter did not step");
   a_ack_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
      transfer_done_ack_oe_o && access |=> transfer_done_ack_oe_o)
      else $error("acknowledge dropped while strobe stands");
endmodule : tsi_switch
`default_nettype wire

// >>> tb/tsi_far_end.sv
// Far-end stream model: serial clock, frame pulse, four input streams, capture of outputs.
// Assumes the bench reads and writes its pattern and capture arrays hierarchically.
`timescale 1ns/10ps
`default_nettype none
module tsi_far_end (
   // Clock and framing
   output logic            serial_shift_clock_o,
   output logic            frame_sync_in_n_o,
   // Streams
   output logic [3:0]      serial_in_lines_o,
   input  wire logic [3:0] serial_out_lines_i,
   input  wire logic [3:0] serial_out_lines_oe_i
);
   // Half of a 4.096 MHz period; the frame drifts a little, which the design must absorb
   localparam realtime HALF = 122.07;
   logic [7:0] next_pattern [128];
   logic [7:0] pattern      [128];
   logic [7:0] rx_byte      [128];
   int         rx_oe        [128];
   logic [7:0] cur_byte     [128];
   int         cur_oe       [128];
   int         frame_cnt;
   initial
   begin
      serial_shift_clock_o = 1'b1;
      frame_sync_in_n_o    = 1'b1;
      serial_in_lines_o    = 4'h0;
      frame_cnt            = 0;
      foreach (next_pattern[i]) next_pattern[i] = 8'h00;
      foreach (cur_oe[i]) cur_oe[i] = 0;
      forever
      begin
         for (int b = 0; b < 256; b++)
         begin
            if (b == 0) frame_sync_in_n_o = 1'b0;
            #HALF serial_shift_clock_o = 1'b0;
            if (b == 0) pattern = next_pattern;
            for (int s = 0; s < 4; s++)
               serial_in_lines_o[s] = pattern[s * 32 + b / 8][7 - b % 8];
            #HALF serial_shift_clock_o = 1'b1;
            frame_sync_in_n_o = 1'b1;
            #HALF serial_shift_clock_o = 1'b0;
            #HALF serial_shift_clock_o = 1'b1;
            for (int s = 0; s < 4; s++)
            begin
               cur_byte[s * 32 + b / 8][7 - b % 8] = serial_out_lines_i[s];
               cur_oe[s * 32 + b / 8] += (serial_out_lines_oe_i[s] === 1'b1);
            end
         end
         rx_byte = cur_byte;
         rx_oe   = cur_oe;
         foreach (cur_oe[i]) cur_oe[i] = 0;
         frame_cnt++;
      end
   end
endmodule : tsi_far_end
`default_nettype wire

// >>> tb/tb.sv
// Bench for the time slot switch: host port tasks, far-end streams, frame-by-frame model.
// Assumes the far-end model in tb/ and the design files in hdl/.
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic       clk_i;
   logic       resetn_i;
   logic       master_output_enable_i;
   logic       chip_select_n_i;
   logic       data_strobe_i;
   logic       read_not_write_i;
   logic [5:0] host_addr_lines_i;
   logic [7:0] host_data_lines_i;
   logic [7:0] host_data_lines_o;
   logic       host_data_lines_oe_o;
   logic       transfer_done_ack_o;
   logic       transfer_done_ack_oe_o;
   logic [3:0] serial_out_lines_o;
   logic [3:0] serial_out_lines_oe_o;
   logic       sck;
   logic       fs_n;
   logic [3:0] rx;
   int         src_mdl [128];
   int         ctl_mdl [128];
   logic [7:0] pat [128];
   logic [7:0] rv;
   bit         pe;
   int         failures;
   int         total_checks;

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   tsi_switch i_tsi_switch (
      .clk_i(clk_i), .resetn_i(resetn_i), .serial_shift_clock_i(sck),
      .frame_sync_in_n_i(fs_n), .serial_in_lines_i(rx),
      .serial_out_lines_o(serial_out_lines_o), .serial_out_lines_oe_o(serial_out_lines_oe_o),
      .master_output_enable_i(master_output_enable_i), .chip_select_n_i(chip_select_n_i),
      .data_strobe_i(data_strobe_i), .read_not_write_i(read_not_write_i),
      .host_addr_lines_i(host_addr_lines_i), .host_data_lines_i(host_data_lines_i),
      .host_data_lines_o(host_data_lines_o), .host_data_lines_oe_o(host_data_lines_oe_o),
      .transfer_done_ack_o(transfer_done_ack_o),
      .transfer_done_ack_oe_o(transfer_done_ack_oe_o));

   tsi_far_end i_tsi_far_end (
      .serial_shift_clock_o(sck), .frame_sync_in_n_o(fs_n), .serial_in_lines_o(rx),
      .serial_out_lines_i(serial_out_lines_o), .serial_out_lines_oe_i(serial_out_lines_oe_o));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   // Strobe is held until the acknowledge is seen, then dropped; select follows the release
   task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] wd,
                       output logic [7:0] q);
      @(negedge clk_i);
      chip_select_n_i   = 1'b0;
      data_strobe_i     = 1'b1;
      read_not_write_i  = rd;
      host_addr_lines_i = a;
      host_data_lines_i = rd ? 8'($urandom) : wd;
      for (int k = 0; k < 40 && transfer_done_ack_oe_o !== 1'b1; k++)
         @(negedge clk_i);
      chk("ack pull", 32'h1, transfer_done_ack_oe_o);
      chk("ack level", 32'h0, transfer_done_ack_o);
      chk("data drive", rd, host_data_lines_oe_o);
      q = host_data_lines_o;
      data_strobe_i = 1'b0;
      for (int k = 0; k < 40 && transfer_done_ack_oe_o !== 1'b0; k++)
         @(negedge clk_i);
      chk("ack release", 32'h0, transfer_done_ack_oe_o);
      chip_select_n_i = 1'b1;
   endtask : xfer

   task automatic next_frame();
      int f;
      f = i_tsi_far_end.frame_cnt;
      wait (i_tsi_far_end.frame_cnt != f);
   endtask : next_frame

   // Only same-slot loopbacks are judged in a frame where the inputs changed
   task automatic check_frame(input bit same_only);
      bit en;
      bit proc;
      for (int i = 0; i < 128; i++)
      begin
         en   = master_output_enable_i && (pe || ctl_mdl[i][0]);
         proc = pe || ctl_mdl[i][2];
         if (same_only && !(src_mdl[i] == i && ctl_mdl[i] == 1)) continue;
         chk("slot drive", en ? 8 : 0, i_tsi_far_end.rx_oe[i]);
         if (en)
            chk("slot byte", proc ? src_mdl[i] : pat[src_mdl[i] % 128],
                i_tsi_far_end.rx_byte[i]);
      end
   endtask : check_frame

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (95000) @(posedge clk_i);
      failures++;
      give_verdict();
   end

   initial
   begin
      int r;
      resetn_i = 1'b0;
      master_output_enable_i = 1'b0;
      chip_select_n_i = 1'b1;
      data_strobe_i = 1'b0;
      read_not_write_i = 1'b1;
      host_addr_lines_i = 6'h00;
      host_data_lines_i = 8'h00;
      pe = 1'b0;
      failures = 0;
      total_checks = 0;
      void'($urandom(32'hf27c));
      repeat (20) @(negedge clk_i);
      chk("reset float", 32'h0, {serial_out_lines_oe_o, host_data_lines_oe_o,
          transfer_done_ack_oe_o});
      resetn_i = 1'b1;
      repeat (3) @(negedge clk_i);
      xfer(1'b1, 6'h00, 8'h00, rv);
      chk("ctl reset", 32'h0, rv);
      data_strobe_i = 1'b1;
      r = 0;
      repeat (20)
      begin
         @(negedge clk_i);
         r += (transfer_done_ack_oe_o !== 1'b0);
      end
      chk("deselected", 32'h0, r);
      data_strobe_i = 1'b0;
      chip_select_n_i = 1'b0;
      repeat (20)
      begin
         @(negedge clk_i);
         r += (transfer_done_ack_oe_o !== 1'b0);
      end
      chk("no strobe", 32'h0, r);
      chip_select_n_i = 1'b1;
      r = $urandom & 8'h3b;
      xfer(1'b0, 6'h1c, 8'(r), rv);
      xfer(1'b1, 6'h00, 8'h00, rv);
      chk("ctl readback", r, rv);
      for (int i = 0; i < 128; i++)
      begin
         r = $urandom % 8;
         ctl_mdl[i] = r == 0 ? 0 : r == 1 ? 5 : r == 2 ? 4 : 1;
         src_mdl[i] = ctl_mdl[i][2] ? $urandom % 256 : $urandom % 128;
         if (i % 32 == 5)
         begin
            ctl_mdl[i] = 1;
            src_mdl[i] = i;
         end
         pat[i] = 8'($urandom);
      end
      i_tsi_far_end.next_pattern = pat;
      for (int m = 2; m < 4; m++)
         for (int s = 0; s < 4; s++)
         begin
            xfer(1'b0, 6'h00, 8'(m * 8 + s), rv);
            for (int c = 0; c < 32; c++)
            begin
               r = m == 2 ? src_mdl[s * 32 + c] : ctl_mdl[s * 32 + c];
               xfer(1'b0, 6'(32 + c), 8'(r), rv);
               xfer(1'b1, 6'(32 + c), 8'h00, rv);
               chk("conn mem", r, rv);
            end
         end
      repeat (3) next_frame();
      check_frame(1'b0);
      @(negedge clk_i);
      master_output_enable_i = 1'b1;
      repeat (2) next_frame();
      check_frame(1'b0);
      next_frame();
      check_frame(1'b0);
      xfer(1'b0, 6'h00, 8'h02, rv);
      xfer(1'b1, 6'h27, 8'h00, rv);
      chk("data mem", pat[71], rv);
      xfer(1'b0, 6'h00, 8'h9a, rv);
      xfer(1'b1, 6'h27, 8'h00, rv);
      chk("split read", pat[71], rv);
      next_frame();
      foreach (pat[i]) i_tsi_far_end.next_pattern[i] = 8'($urandom);
      next_frame();
      check_frame(1'b1);
      pat = i_tsi_far_end.next_pattern;
      next_frame();
      check_frame(1'b0);
      xfer(1'b0, 6'h00, 8'h40, rv);
      repeat (2) next_frame();
      pe = 1'b1;
      check_frame(1'b0);
      @(negedge clk_i);
      resetn_i = 1'b0;
      repeat (4) @(negedge clk_i);
      chk("mid reset float", 32'h0, {serial_out_lines_oe_o, host_data_lines_oe_o});
      resetn_i = 1'b1;
      pe = 1'b0;
      repeat (3) @(negedge clk_i);
      xfer(1'b1, 6'h00, 8'h00, rv);
      chk("ctl cleared", 32'h0, rv);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
